// ### src/event_controller.v
// Function
// - stop codes 0/1: panel voltage above/below threshold
// - stop codes 2/3: sense voltage above/below
// - stop 4/5: button off/on and late
// - stop 8-11 repeat every 1,3,6,12 minutes
// - stop 12: time beyond setting, range 0-25.5h
// - stop 14/15 end after run time
// - panel voltage comparisons settle up to six minutes
// - qualifier code 0 always active
// - qualifier 5 float-night, 6 float-day
// - guard 0-6 cutoff wins, 8-14 event wins
// - guard codes: always,temp,sense,time above/below
// - sense settings 0.1V steps, code 80 zero
// - start needs start, qualifier, guard together
// - stop, qualifier or guard loss ends event
// - event on/off indication shown
// - digit one: start when off, stop when on
// - digits two, three: qualifier and guard
// - time counts tenths, wraps after 23.9
// - start 0-3 as stop 0-3; start 4/5 button on/off and late
// - start 8-11 repeat 10,30,60,120 minutes
// - start 12 time; 14/15 programmed rate
// - disabled unless regulation program four
`timescale 1ns/1ps
`default_nettype none
`include "event_controller_regs.vh"
module event_controller #(
	parameter [32:0] CYCLES_PER_MINUTE = `CYCLES_PER_MINUTE_COUNT,
	parameter PANEL_DELAY_MIN = `PANEL_DELAY_MINUTES
) (
	input wire core_clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire [7:0] panelVoltage,
	input wire [7:0] externalSenseVoltage,
	input wire [7:0] temperature,
	input wire pushButtonInput,
	input wire floatState,
	input wire nightFlag,
	input wire lowBatteryCutoff,
	output reg eventOutput,
	output reg eventActive,
	output reg eventOffIndicator,
	output reg [2:0] statusDigits
);

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	// one-cycle wait so read data always comes from a flop
	reg ack_q;
	reg [2:0] regulationProgramNumber_q;
	reg [3:0] startConditionSelect_q;
	reg [7:0] startTime_q;
	reg [7:0] startRate_q;
	reg [3:0] stopConditionSelect_q;
	reg [7:0] stopTime_q;
	reg [7:0] stopRun_q;
	reg [3:0] chargeStateQualifier_q;
	reg [3:0] guardConditionSelect_q;
	reg [7:0] guardSetting_q;
	reg [7:0] panelVoltageThreshold_q;
	reg [7:0] senseThreshold_q;
	reg [7:0] timeOfDay_q;
	wire timeWrite;
	wire access;
	wire [7:0] byteAddr;
	assign access = avs_read | avs_write;
	assign avs_waitrequest = access & ~ack_q;
	assign byteAddr = {2'b00, avs_address, 2'b00};

	// settle of request: ack one cycle after it appears
	always @(posedge core_clk)
	begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= access & ~ack_q;
	end

	// register writes, lanes taken by byte enable
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			regulationProgramNumber_q <= 3'h0;
			startConditionSelect_q <= 4'h6;
			startTime_q <= 8'h00;
			startRate_q <= 8'h00;
			stopConditionSelect_q <= 4'h6;
			stopTime_q <= 8'h00;
			stopRun_q <= 8'h00;
			chargeStateQualifier_q <= 4'h0;
			guardConditionSelect_q <= 4'h0;
			guardSetting_q <= 8'h00;
			panelVoltageThreshold_q <= 8'h00;
			senseThreshold_q <= `SENSE_ZERO_CODE_REAL;
		end
		else if (avs_write & ~ack_q)
		begin
			case (byteAddr)
				`OFS_CTRL:
				begin
					if (avs_byteenable[0])
						regulationProgramNumber_q <= avs_writedata[2:0];
				end
				`OFS_START_CFG:
				begin
					if (avs_byteenable[0])
						startConditionSelect_q <= avs_writedata[3:0];
					if (avs_byteenable[1])
						startTime_q <= avs_writedata[15:8];
					if (avs_byteenable[2])
						startRate_q <= avs_writedata[23:16];
					if (avs_byteenable[3])
						panelVoltageThreshold_q <= avs_writedata[31:24];
				end
				`OFS_STOP_CFG:
				begin
					if (avs_byteenable[0])
						stopConditionSelect_q <= avs_writedata[3:0];
					if (avs_byteenable[1])
						stopTime_q <= avs_writedata[15:8];
					if (avs_byteenable[2])
						stopRun_q <= avs_writedata[23:16];
					if (avs_byteenable[3])
						senseThreshold_q <= avs_writedata[31:24];
				end
				`OFS_QUAL_CFG:
				begin
					if (avs_byteenable[0])
						chargeStateQualifier_q <= avs_writedata[3:0];
					if (avs_byteenable[1])
						guardConditionSelect_q <= avs_writedata[11:8];
					if (avs_byteenable[2])
						guardSetting_q <= avs_writedata[23:16];
				end
				default:
				begin
				end
			endcase
		end
	end

	// time of day written via the inputs register, byte 0
	assign timeWrite = avs_write & ~ack_q & (byteAddr == `OFS_INPUTS) & avs_byteenable[0];

	// ----------------------------------------
	// time base
	// ----------------------------------------
	reg [32:0] cycleCount_q;
	reg [2:0] minuteInTenth_q;
	reg [10:0] minuteCount_q;
	wire minuteTick;
	assign minuteTick = (cycleCount_q == CYCLES_PER_MINUTE - 33'h1);

	// free running minute counter plus tenth-hour clock; wraps 23.9 to 0
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			cycleCount_q <= 33'h0;
			minuteInTenth_q <= 3'h0;
			timeOfDay_q <= 8'h00;
			minuteCount_q <= 11'h000;
		end
		else
		begin
			cycleCount_q <= minuteTick ? 33'h0 : cycleCount_q + 33'h1;
			if (timeWrite)
			begin
				timeOfDay_q <= avs_writedata[7:0];
				minuteInTenth_q <= 3'h0;
			end
			else if (minuteTick)
			begin
				if (minuteInTenth_q == `TENTH_HOUR_MINUTES - 1)
				begin
					minuteInTenth_q <= 3'h0;
					timeOfDay_q <= (timeOfDay_q >= `TIME_DAY_TENTHS - 8'h01) ? 8'h00 : timeOfDay_q + 8'h01;
				end
				else
					minuteInTenth_q <= minuteInTenth_q + 3'h1;
			end
			if (minuteTick)
				minuteCount_q <= minuteCount_q + 11'h001;
		end
	end

	// ----------------------------------------
	// panel voltage settle
	// ----------------------------------------
	// panel comparisons are re-sampled once per delay window; avoids chatter
	reg [3:0] panelMinutes_q;
	reg panelAbove_q;
	reg panelBelow_q;
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			panelMinutes_q <= 4'h0;
			panelAbove_q <= 1'b0;
			panelBelow_q <= 1'b0;
		end
		else if (minuteTick)
		begin
			if (panelMinutes_q >= PANEL_DELAY_MIN[3:0] - 4'h1)
			begin
				panelMinutes_q <= 4'h0;
				panelAbove_q <= panelVoltage > panelVoltageThreshold_q;
				panelBelow_q <= panelVoltage < panelVoltageThreshold_q;
			end
			else
				panelMinutes_q <= panelMinutes_q + 4'h1;
		end
	end

	// ----------------------------------------
	// condition evaluation
	// ----------------------------------------
	reg [10:0] runMinutes_q;
	reg [10:0] sinceStart_q;
	reg startCond;
	reg stopCond;
	reg chargeQual;
	reg guardQual;
	reg [10:0] stopLimit;
	reg [10:0] rateLimit;
	wire senseAbove;
	wire senseBelow;
	wire startLate;
	wire stopLate;
	assign senseAbove = externalSenseVoltage > senseThreshold_q;
	assign senseBelow = externalSenseVoltage < senseThreshold_q;
	assign startLate = timeOfDay_q > startTime_q;
	assign stopLate = timeOfDay_q > stopTime_q;

	// repeat periods measured on the free minute counter
	function pulseEvery;
		input [10:0] minutes;
		input [10:0] period;
		begin
			pulseEvery = (minutes % period) == 11'h000;
		end
	endfunction

	always @*
	begin
		stopLimit = (stopConditionSelect_q == 4'hF) ? {3'h0, stopRun_q} * 11'h006 : {3'h0, stopRun_q};
		rateLimit = (startConditionSelect_q == 4'hF) ? {3'h0, startRate_q} * 11'h006 : {3'h0, startRate_q};
		case (startConditionSelect_q)
			4'h0: startCond = panelAbove_q;
			4'h1: startCond = panelBelow_q;
			4'h2: startCond = senseAbove;
			4'h3: startCond = senseBelow;
			4'h4: startCond = pushButtonInput & startLate;
			4'h5: startCond = ~pushButtonInput & startLate;
			4'h8: startCond = startLate & pulseEvery(minuteCount_q, 11'd10);
			4'h9: startCond = startLate & pulseEvery(minuteCount_q, 11'd30);
			4'hA: startCond = startLate & pulseEvery(minuteCount_q, 11'd60);
			4'hB: startCond = startLate & pulseEvery(minuteCount_q, 11'd120);
			4'hC: startCond = startLate;
			4'hE, 4'hF: startCond = (sinceStart_q >= rateLimit);
			default: startCond = 1'b0;
		endcase
		case (stopConditionSelect_q)
			4'h0: stopCond = panelAbove_q;
			4'h1: stopCond = panelBelow_q;
			4'h2: stopCond = senseAbove;
			4'h3: stopCond = senseBelow;
			4'h4: stopCond = ~pushButtonInput & stopLate;
			4'h5: stopCond = pushButtonInput & stopLate;
			4'h8: stopCond = stopLate & pulseEvery(minuteCount_q, 11'd1);
			4'h9: stopCond = stopLate & pulseEvery(minuteCount_q, 11'd3);
			4'hA: stopCond = stopLate & pulseEvery(minuteCount_q, 11'd6);
			4'hB: stopCond = stopLate & pulseEvery(minuteCount_q, 11'd12);
			4'hC: stopCond = stopLate;
			4'hE, 4'hF: stopCond = (runMinutes_q >= stopLimit);
			default: stopCond = 1'b0;
		endcase
		case (chargeStateQualifier_q)
			4'h0: chargeQual = 1'b1;
			4'h1: chargeQual = floatState;
			4'h2: chargeQual = nightFlag;
			4'h3: chargeQual = ~nightFlag;
			4'h5: chargeQual = floatState & nightFlag;
			4'h6: chargeQual = floatState & ~nightFlag;
			default: chargeQual = 1'b0;
		endcase
		case (guardConditionSelect_q[2:0])
			3'h0: guardQual = 1'b1;
			3'h1: guardQual = temperature > guardSetting_q;
			3'h2: guardQual = temperature < guardSetting_q;
			3'h3: guardQual = externalSenseVoltage > guardSetting_q;
			3'h4: guardQual = externalSenseVoltage < guardSetting_q;
			3'h5: guardQual = timeOfDay_q > guardSetting_q;
			3'h6: guardQual = timeOfDay_q < guardSetting_q;
			default: guardQual = 1'b0;
		endcase
		if (guardConditionSelect_q == 4'hF)
			guardQual = 1'b0;
	end

	// ----------------------------------------
	// event state
	// ----------------------------------------
	wire enabled;
	wire cutoffWins;
	assign enabled = regulationProgramNumber_q == `REGULATION_PROGRAM_EVENT;
	assign cutoffWins = ~guardConditionSelect_q[3];

	// run and rate counters restart on each event start
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			eventActive <= 1'b0;
			runMinutes_q <= 11'h000;
			sinceStart_q <= 11'h000;
		end
		else if (~enabled)
		begin
			eventActive <= 1'b0;
			runMinutes_q <= 11'h000;
			sinceStart_q <= 11'h000;
		end
		else if (~eventActive)
		begin
			if (startCond & chargeQual & guardQual)
			begin
				eventActive <= 1'b1;
				runMinutes_q <= 11'h000;
				sinceStart_q <= 11'h000;
			end
			else if (minuteTick)
				sinceStart_q <= sinceStart_q + 11'h001;
		end
		else
		begin
			if (stopCond | ~chargeQual | ~guardQual)
				eventActive <= 1'b0;
			if (minuteTick)
			begin
				runMinutes_q <= runMinutes_q + 11'h001;
				sinceStart_q <= sinceStart_q + 11'h001;
			end
		end
	end

	// outputs and status digits, registered
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			eventOutput <= 1'b0;
			eventOffIndicator <= 1'b1;
			statusDigits <= 3'h0;
		end
		else
		begin
			eventOutput <= eventActive & ~(cutoffWins & lowBatteryCutoff);
			eventOffIndicator <= ~eventActive;
			statusDigits[2] <= eventActive ? stopCond : startCond;
			statusDigits[1] <= chargeQual;
			statusDigits[0] <= guardQual;
		end
	end

	// read mux; unmapped addresses read zero
	always @(posedge core_clk)
	begin
		if (rst)
			avs_readdata <= 32'h0;
		else if (avs_read & ~ack_q)
		begin
			case (byteAddr)
				`OFS_CTRL: avs_readdata <= {29'h0, regulationProgramNumber_q};
				`OFS_START_CFG: avs_readdata <= {panelVoltageThreshold_q, startRate_q, startTime_q, 4'h0, startConditionSelect_q};
				`OFS_STOP_CFG: avs_readdata <= {senseThreshold_q, stopRun_q, stopTime_q, 4'h0, stopConditionSelect_q};
				`OFS_QUAL_CFG: avs_readdata <= {8'h00, guardSetting_q, 4'h0, guardConditionSelect_q, 4'h0, chargeStateQualifier_q};
				`OFS_INPUTS: avs_readdata <= {13'h0, runMinutes_q, timeOfDay_q};
				`OFS_STATUS: avs_readdata <= {26'h0, eventOutput, eventOffIndicator, eventActive, statusDigits};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

endmodule
`default_nettype wire

// ### shared/event_controller_regs.vh
`ifndef EVENT_CONTROLLER_REGS_VH
`define EVENT_CONTROLLER_REGS_VH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_START_CFG 8'h04
`define OFS_STOP_CFG 8'h08
`define OFS_QUAL_CFG 8'h0C
`define OFS_INPUTS 8'h10
`define OFS_STATUS 8'h14
// field positions
`define CTRL_REGULATION_PROGRAM_NUMBER_LSB 0
`define CTRL_REGULATION_PROGRAM_NUMBER_W 3
`define REGULATION_PROGRAM_EVENT 3'h4
`define SENSE_ZERO_CODE 8'h50
`define SENSE_ZERO_CODE_REAL 8'h50
// time base: one tenth hour = 6 minutes
`define CLK_HZ 125000000
`define SECONDS_PER_MINUTE 60
// core clock cycles in one minute at 125 MHz; needs 33 bits
`define CYCLES_PER_MINUTE_COUNT 33'h1BF08EB00
`define TENTH_HOUR_MINUTES 6
`define TIME_DAY_TENTHS 8'hF0
`define PANEL_DELAY_MINUTES 6
`endif

// ### verification/event_controller_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module event_controller_checker (
	input wire core_clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire lowBatteryCutoff,
	input wire eventOutput,
	input wire eventActive,
	input wire eventOffIndicator,
	input wire [2:0] statusDigits
);
	// ----------------
	// port relations
	// ----------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	off_indicator_a: assert property (eventOffIndicator == !$past(eventActive))
		else $error("off indicator disagrees with event state");
	cutoff_gate_a: assert property (!$past(lowBatteryCutoff) |-> eventOutput == $past(eventActive))
		else $error("terminal drive differs from event state");
	reset_state_a: assert property ($past(rst) |-> !eventActive && eventOffIndicator && avs_readdata == 32'h0)
		else $error("outputs not cleared by reset");
	wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first request cycle");
	wait_second_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest high in second request cycle");
	unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5 |-> avs_readdata == 32'h0)
		else $error("unmapped read returned data");
	start_qual_a: assert property ($rose(eventActive) |-> statusDigits[1:0] == 2'b11)
		else $error("event started without both qualifiers");
	loss_stop_a: assert property (eventActive |-> statusDigits[1:0] == 2'b11)
		else $error("event kept after qualifier loss");
endmodule
bind event_controller event_controller_checker chk_i (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .lowBatteryCutoff, .eventOutput, .eventActive, .eventOffIndicator, .statusDigits);
`default_nettype wire

// ### verification/load_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module load_side_model (
	input wire logic core_clk,
	input wire logic eventOutput,
	input wire logic pressCmd,
	output logic pushButtonInput,
	output logic terminalOn
);
	// ----------------
	// switch and terminal
	// ----------------
	initial pushButtonInput = 1'b0;
	// contact lags the press by a clock, as a real switch never lands on the edge
	always @(posedge core_clk)
	begin
		pushButtonInput <= pressCmd;
		terminalOn <= eventOutput;
	end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int CPM = 20;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rdata, r;
	logic avs_waitrequest, pushButtonInput, terminalOn, eventOutput, eventActive, eventOffIndicator;
	logic [2:0] statusDigits;
	logic [7:0] temperature = 8'h0;
	logic [7:0] panelVoltage = 8'h0;
	logic [7:0] externalSenseVoltage = 8'h50;
	logic floatState = 1'b0;
	logic nightFlag = 1'b0;
	logic lowBatteryCutoff = 1'b0;
	logic pressCmd = 1'b0;
	logic [31:0] seed = 32'h1ECEB17C;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int e, n;
	// ----------------
	// design and far side
	// ----------------
	event_controller #(.CYCLES_PER_MINUTE(CPM)) event_controller_i (.core_clk(core_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.panelVoltage(panelVoltage), .externalSenseVoltage(externalSenseVoltage), .temperature(temperature),
		.pushButtonInput(pushButtonInput), .floatState(floatState), .nightFlag(nightFlag),
		.lowBatteryCutoff(lowBatteryCutoff), .eventOutput(eventOutput), .eventActive(eventActive),
		.eventOffIndicator(eventOffIndicator), .statusDigits(statusDigits));
	load_side_model load_side_model_i (.core_clk(core_clk), .eventOutput(eventOutput), .pressCmd(pressCmd),
		.pushButtonInput(pushButtonInput), .terminalOn(terminalOn));
	initial r = 32'h0;
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	// hang guard: the tests need under a thousand cycles
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	// ----------------
	// tasks and reference model
	// ----------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int qualModel(int c, int f, int nt);
		case (c)
			0: return 1;
			1: return f;
			2: return nt;
			3: return 1 - nt;
			5: return f & nt;
			6: return f & (1 - nt);
			default: return 0;
		endcase
	endfunction
	// bits say whether temperature, sense and time lie above the setting
	function automatic int guardModel(int c, int t, int s, int d);
		case (c % 8)
			0: return 1;
			1: return t;
			2: return 1 - t;
			3: return s;
			4: return 1 - s;
			5: return d;
			6: return 1 - d;
			default: return 0;
		endcase
	endfunction
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0 && k < 20)
		begin
			@(posedge core_clk);
			k++;
		end
		if (k == 20)
			miscompares++;
		// taken at the edge that saw waitrequest low; release right after it
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------
	// scenarios
	// ----------------
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		cmp(eventOffIndicator, 1, "off after reset");
		bus(0, 4'hF, 32'h0);
		cmp(rdata, 32'h0, "unmapped read");
		bus(1, 4'h4, 32'h32);
		bus(1, 4'h1, 32'hC);
		bus(1, 4'h2, 32'hFC0C);
		bus(1, 4'h3, 32'h0);
		bus(1, 4'h0, 32'h0);
		repeat (8) @(posedge core_clk);
		cmp(eventActive, 0, "program zero");
		bus(1, 4'h0, 32'h4);
		repeat (8) @(posedge core_clk);
		bus(0, 4'h5, 32'h0);
		cmp(rdata[5:0], 6'h2B, "status");
		$display("test program done");
		// qualifier codes 0-7 against float and night
		for (int c = 0; c < 8; c++)
			for (int fn = 0; fn < 4; fn++)
			begin
				floatState <= fn[1];
				nightFlag <= fn[0];
				bus(1, 4'h3, c);
				repeat (6) @(posedge core_clk);
				e = qualModel(c, fn / 2, fn % 2);
				cmp(statusDigits[1], e, "qualifier");
				cmp(eventActive, e, "event");
				cmp(statusDigits[2], 1 - e, "first digit");
			end
		$display("test qualifier done");
		// every guard code with inputs either side of a setting of 100
		for (int c = 0; c < 16; c++)
		begin
			r = xs();
			panelVoltage <= r[11:4];
			temperature <= r[0] ? 8'h82 : 8'h46;
			externalSenseVoltage <= r[1] ? 8'h82 : 8'h46;
			lowBatteryCutoff <= r[2];
			bus(1, 4'h4, r[3] ? 32'h82 : 32'h46);
			bus(1, 4'h3, {8'h00, 8'h64, 4'h0, c[3:0], 8'h00});
			repeat (6) @(posedge core_clk);
			e = guardModel(c, r[0], r[1], r[3]);
			cmp(statusDigits[0], e, "guard");
			cmp(eventOutput, e & !(r[2] & (c < 8)), "cutoff");
			cmp(terminalOn, e & !(r[2] & (c < 8)), "terminal");
		end
		$display("test guard done");
		lowBatteryCutoff <= 1'b0;
		bus(1, 4'h1, 32'h4);
		bus(1, 4'h2, 32'h3000E);
		bus(1, 4'h3, 32'h0);
		cmp(eventActive, 0, "idle before press");
		// a second press proves the run count starts over
		for (int k = 0; k < 2; k++)
		begin
			pressCmd <= 1'b1;
			repeat (4) @(posedge core_clk);
			pressCmd <= 1'b0;
			repeat (30) @(posedge core_clk);
			cmp(eventActive, 1, "button start");
			n = 34;
			while (eventActive === 1'b1 && n < 300)
			begin
				@(posedge core_clk);
				n++;
			end
			cmp(n >= 2 * CPM && n <= 4 * CPM, 1, "run time");
		end
		$display("test run time done");
		// panel compares take effect only at the next settle sample
		panelVoltage <= 8'h46;
		bus(1, 4'h2, 32'h64000001);
		bus(1, 4'h1, 32'h64000000);
		repeat (7 * CPM) @(posedge core_clk);
		cmp(eventActive, 0, "panel low");
		panelVoltage <= 8'hC8;
		n = 0;
		while (eventActive !== 1'b1 && n < 7 * CPM)
		begin
			@(posedge core_clk);
			n++;
		end
		cmp(n <= 6 * CPM + 4, 1, "panel delay");
		// sense threshold of 100 is two volts above the zero code
		externalSenseVoltage <= 8'h46;
		bus(1, 4'h2, 32'h64000003);
		bus(1, 4'h1, 32'h2);
		repeat (4) @(posedge core_clk);
		cmp(eventActive, 0, "sense low");
		externalSenseVoltage <= 8'h82;
		repeat (4) @(posedge core_clk);
		cmp(eventActive, 1, "sense high");
		cmp(statusDigits[2], 0, "stop digit");
		$display("test panel and sense done");
		final_report();
	end
endmodule
`default_nettype wire
